// ### src/lbt_params.svh
`ifndef LBT_PARAMS_SVH
`define LBT_PARAMS_SVH
`define LBT_SW_TERMINAL 8'h05
`define LBT_SW_MODEM 8'h06
`define LBT_SW_DIAG 8'h03
`define LBT_NUM_PORTS 16
`define LBT_LINE_MAX 8'h80
`define LBT_PAUSE_AT 8'h50
`define LBT_CR 8'h0d
`define LBT_LF 8'h0a
`define LBT_CLK_HZ 50000000
`define LBT_PAUSE_S 10
`define LBT_PAUSE_CYCLES (`LBT_PAUSE_S * `LBT_CLK_HZ)
`define LBT_BLINK_MS 500
`define LBT_BLINK_CYCLES (`LBT_CLK_HZ / 1000 * `LBT_BLINK_MS)
`define LBT_DIAG_LIT_MS 1000
`define LBT_DIAG_LIT_CYCLES (`LBT_CLK_HZ / 1000 * `LBT_DIAG_LIT_MS)
`define LBT_BANNER_LEN 6'd36
`define LBT_BANNER_TEXT_LEN 30
`define LBT_MODEM_SEED 8'h01
`define LBT_MODEM_CYCLE_BYTES 8'h40
`define LBT_MODEM_ERR_CODE 20'hfffff
`define LBT_LAMP_A 0
`define LBT_LAMP_B 1
`define LBT_LAMP_C 2
`define LBT_LAMP_D 3
`define LBT_LAMP_E 4
`define LBT_LAMP_PORT0 5
`define LBT_REG_CTRL 8'h00
`define LBT_REG_STATUS 8'h04
`define LBT_REG_MASK 8'h08
`define LBT_REG_ENQACK 8'h0c
`define LBT_REG_MODE 8'h10
`define LBT_REG_CYCLES 8'h14
`define LBT_REG_LAMPS 8'h18
`define LBT_EV_START 0
`define LBT_EV_LINE 1
`define LBT_EV_MPASS 2
`define LBT_EV_MFAIL 3
`define LBT_CTRL_RESET 1'b0
`define LBT_MASK_RESET 4'h0
`define LBT_ENQACK_RESET 16'h0000
`endif

// ### src/lbt_pkg.sv
`include "lbt_params.svh"
package lbt_pkg;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } lbt_byte_type;

    typedef enum logic [5:0] {
        LBT_WAIT_POST = 6'h01,
        LBT_TERM = 6'h02,
        LBT_MODEM = 6'h04,
        LBT_DIAG = 6'h08,
        LBT_MFAIL = 6'h10,
        LBT_IDLE = 6'h20
    } lbt_state_type;

    typedef enum logic [4:0] {
        LBT_P_OFF = 5'h01,
        LBT_P_BANNER = 5'h02,
        LBT_P_ECHO = 5'h04,
        LBT_P_REPLAY = 5'h08,
        LBT_P_PAUSE = 5'h10
    } lbt_port_state_type;

    localparam logic [8*`LBT_BANNER_TEXT_LEN-1:0] LBT_BANNER_TEXT = "LOOP-BACK TEST FEATURE ENABLED";

    function automatic logic [7:0] lbt_banner_char(input logic [5:0] idx);
        logic [5:0] t;
        t = idx - 6'd3;
        if (idx == 6'd0 || idx == 6'd33) begin
            return `LBT_CR;
        end else if (idx < 6'd3 || idx > 6'd33) begin
            return `LBT_LF;
        end
        return LBT_BANNER_TEXT[8*(`LBT_BANNER_TEXT_LEN-1-int'(t)) +: 8];
    endfunction

    function automatic logic [7:0] lbt_lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
endpackage

// ### src/lbt_port_engine.sv
`timescale 1ns/1ps
`default_nettype none
module lbt_port_engine
    import lbt_pkg::*;
#(
    parameter int unsigned PAUSE_CYCLES = `LBT_PAUSE_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic enqack_mode,
    input wire lbt_byte_type rx,
    output logic rx_ready,
    output lbt_byte_type tx,
    input wire logic tx_ready,
    output logic line_done
);
    typedef struct packed {
        lbt_port_state_type state;
        logic [7:0] idx;
        logic [7:0] count;
        logic add_cr;
        logic [31:0] pause_cnt;
        lbt_byte_type tx;
        logic rx_ready;
        logic line_done;
    } lbt_port_regs_type;

    lbt_port_regs_type port_reg;
    lbt_port_regs_type port_next;
    logic [7:0] line_mem [0:127];
    logic store;

    always_comb begin
        port_next = port_reg;
        port_next.line_done = 1'b0;
        store = 1'b0;
        if (port_reg.tx.valid && tx_ready) begin
            port_next.tx.valid = 1'b0;
        end
        case (port_reg.state)
            LBT_P_OFF: begin
                if (run) begin
                    port_next.state = LBT_P_BANNER;
                    port_next.idx = 8'h00;
                end
            end
            LBT_P_BANNER: begin
                if (!port_reg.tx.valid) begin
                    port_next.tx = '{valid: 1'b1, data: lbt_banner_char(port_reg.idx[5:0])};
                    port_next.idx = port_reg.idx + 8'h01;
                    if (port_reg.idx[5:0] == `LBT_BANNER_LEN - 6'd1) begin
                        port_next.state = LBT_P_ECHO;
                        port_next.count = 8'h00;
                    end
                end
            end
            LBT_P_ECHO: begin
                if (rx.valid && port_reg.rx_ready) begin
                    store = 1'b1;
                    port_next.tx = rx;
                    port_next.count = port_reg.count + 8'h01;
                    port_next.idx = 8'h00;
                    if (rx.data == `LBT_CR || port_reg.count + 8'h01 == `LBT_LINE_MAX) begin
                        port_next.state = LBT_P_REPLAY;
                        port_next.add_cr = (rx.data != `LBT_CR);
                    end else if (!enqack_mode && port_reg.count + 8'h01 == `LBT_PAUSE_AT) begin
                        port_next.state = LBT_P_PAUSE;
                        port_next.pause_cnt = 32'h0;
                    end
                end
            end
            LBT_P_REPLAY: begin
                if (!port_reg.tx.valid) begin
                    if (port_reg.idx < port_reg.count) begin
                        port_next.tx = '{valid: 1'b1, data: line_mem[port_reg.idx[6:0]]};
                        port_next.idx = port_reg.idx + 8'h01;
                    end else if (port_reg.add_cr) begin
                        port_next.tx = '{valid: 1'b1, data: `LBT_CR};
                        port_next.add_cr = 1'b0;
                    end else begin
                        port_next.state = LBT_P_ECHO;
                        port_next.count = 8'h00;
                        port_next.line_done = 1'b1;
                    end
                end
            end
            LBT_P_PAUSE: begin
                port_next.pause_cnt = port_reg.pause_cnt + 32'h1;
                if (port_reg.pause_cnt == PAUSE_CYCLES - 1) begin
                    port_next.state = LBT_P_ECHO;
                end
            end
            default: begin
                port_next.state = LBT_P_OFF;
            end
        endcase
        if (!run) begin
            port_next.state = LBT_P_OFF;
            port_next.tx.valid = 1'b0;
        end
        // Accept only while the echo slot is free, so no received character is dropped
        port_next.rx_ready = run && port_next.state == LBT_P_ECHO && !port_next.tx.valid;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_reg <= '{state: LBT_P_OFF, default: '0};
        end else begin
            port_reg <= port_next;
        end
    end

    always_ff @(posedge clk) begin
        if (store) begin
            line_mem[port_reg.count[6:0]] <= rx.data;
        end
    end

    assign tx = port_reg.tx;
    assign rx_ready = port_reg.rx_ready;
    assign line_done = port_reg.line_done;
endmodule
`default_nettype wire

// ### src/lbt_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module lbt_sequencer
    import lbt_pkg::*;
#(
    parameter int unsigned PAUSE_CYCLES = `LBT_PAUSE_CYCLES,
    parameter int unsigned BLINK_CYCLES = `LBT_BLINK_CYCLES,
    parameter int unsigned DIAG_LIT_CYCLES = `LBT_DIAG_LIT_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] cfg_switches,
    input wire logic post_done,
    input wire logic post_fail,
    input wire logic diag_pass,
    input wire lbt_byte_type [`LBT_NUM_PORTS-1:0] port_rx,
    output logic [`LBT_NUM_PORTS-1:0] port_rx_ready,
    output lbt_byte_type [`LBT_NUM_PORTS-1:0] port_tx,
    input wire logic [`LBT_NUM_PORTS-1:0] port_tx_ready,
    output logic port_rate_9600,
    output lbt_byte_type net_tx,
    input wire logic net_tx_ready,
    input wire lbt_byte_type net_rx,
    output logic [20:0] lamps,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    typedef struct packed {
        lbt_state_type state;
        logic [7:0] sw;
        logic sw_taken;
        logic [31:0] blink_cnt;
        logic blink;
        logic [31:0] hold_cnt;
        logic [15:0] act_seen;
        logic [20:0] lamps;
        logic rate_9600;
        logic [3:0] status;
        logic [3:0] mask;
        logic [15:0] enqack;
        logic [31:0] rdata;
        logic irq;
        lbt_byte_type net_tx;
        logic [7:0] tx_lfsr;
        logic [7:0] rx_lfsr;
        logic [7:0] match_cnt;
        logic [31:0] cycles;
    } lbt_regs_type;

    lbt_regs_type seq_reg;
    lbt_regs_type seq_next;
    logic term_run;
    logic [`LBT_NUM_PORTS-1:0] line_done;
    logic [`LBT_NUM_PORTS-1:0] rx_taken;
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    logic blink_tick;

    assign term_run = (seq_reg.state == LBT_TERM);

    genvar gi;
    generate
        for (gi = 0; gi < `LBT_NUM_PORTS; gi = gi + 1) begin : g_port
            lbt_port_engine #(
                .PAUSE_CYCLES(PAUSE_CYCLES)
            ) u_port (
                .clk(clk),
                .sys_rst(sys_rst),
                .run(term_run),
                .enqack_mode(seq_reg.enqack[gi]),
                .rx(port_rx[gi]),
                .rx_ready(port_rx_ready[gi]),
                .tx(port_tx[gi]),
                .tx_ready(port_tx_ready[gi]),
                .line_done(line_done[gi])
            );
            assign rx_taken[gi] = port_rx[gi].valid && port_rx_ready[gi];
        end
    endgenerate

    always_comb begin
        seq_next = seq_reg;
        ev_set = 4'h0;
        ev_clr = 4'h0;
        blink_tick = 1'b0;

        // Switches are sampled once, on the first cycle after reset is released
        if (!seq_reg.sw_taken) begin
            seq_next.sw = cfg_switches;
            seq_next.sw_taken = 1'b1;
        end

        // Free running blink divider, half period per toggle
        seq_next.blink_cnt = seq_reg.blink_cnt + 32'h1;
        if (seq_reg.blink_cnt == BLINK_CYCLES - 1) begin
            seq_next.blink_cnt = 32'h0;
            seq_next.blink = !seq_reg.blink;
            blink_tick = 1'b1;
        end
        if (seq_reg.hold_cnt != 32'h0) begin
            seq_next.hold_cnt = seq_reg.hold_cnt - 32'h1;
        end

        case (seq_reg.state)
            LBT_WAIT_POST: begin
                if (seq_reg.sw_taken && post_done) begin
                    if (post_fail) begin
                        seq_next.state = LBT_IDLE;
                    end else if (seq_reg.sw == `LBT_SW_TERMINAL) begin
                        seq_next.state = LBT_TERM;
                        ev_set[`LBT_EV_START] = 1'b1;
                    end else if (seq_reg.sw == `LBT_SW_MODEM) begin
                        seq_next.state = LBT_MODEM;
                        seq_next.tx_lfsr = `LBT_MODEM_SEED;
                        seq_next.rx_lfsr = `LBT_MODEM_SEED;
                        seq_next.match_cnt = 8'h00;
                        ev_set[`LBT_EV_START] = 1'b1;
                    end else if (seq_reg.sw == `LBT_SW_DIAG) begin
                        seq_next.state = LBT_DIAG;
                        ev_set[`LBT_EV_START] = 1'b1;
                    end else begin
                        seq_next.state = LBT_IDLE;
                    end
                end
            end
            LBT_TERM: begin
                if (|line_done) begin
                    ev_set[`LBT_EV_LINE] = 1'b1;
                end
            end
            LBT_MODEM: begin
                if (seq_reg.net_tx.valid && net_tx_ready) begin
                    seq_next.net_tx.valid = 1'b0;
                end
                // One pattern byte per free slot; the slot stays empty for one cycle after each byte is taken
                if (!seq_reg.net_tx.valid) begin
                    seq_next.net_tx = '{valid: 1'b1, data: seq_reg.tx_lfsr};
                    seq_next.tx_lfsr = lbt_lfsr_next(seq_reg.tx_lfsr);
                end
                if (net_rx.valid) begin
                    if (net_rx.data == seq_reg.rx_lfsr) begin
                        seq_next.rx_lfsr = lbt_lfsr_next(seq_reg.rx_lfsr);
                        seq_next.match_cnt = seq_reg.match_cnt + 8'h01;
                        if (seq_reg.match_cnt == `LBT_MODEM_CYCLE_BYTES - 8'h01) begin
                            seq_next.match_cnt = 8'h00;
                            seq_next.cycles = seq_reg.cycles + 32'h1;
                            seq_next.hold_cnt = BLINK_CYCLES;
                            ev_set[`LBT_EV_MPASS] = 1'b1;
                        end
                    end else begin
                        seq_next.state = LBT_MFAIL;
                        seq_next.net_tx.valid = 1'b0;
                        ev_set[`LBT_EV_MFAIL] = 1'b1;
                    end
                end
            end
            LBT_DIAG: begin
                if (diag_pass) begin
                    seq_next.hold_cnt = DIAG_LIT_CYCLES;
                    seq_next.cycles = seq_reg.cycles + 32'h1;
                end
            end
            LBT_MFAIL: begin
                seq_next.net_tx.valid = 1'b0;
            end
            LBT_IDLE: begin
                seq_next.state = LBT_IDLE;
            end
            default: begin
                seq_next.state = LBT_IDLE;
            end
        endcase

        // Port activity is gathered over a blink half period so a single key press stays visible
        if (blink_tick) begin
            seq_next.act_seen = rx_taken;
        end else begin
            seq_next.act_seen = seq_reg.act_seen | rx_taken;
        end

        seq_next.lamps = 21'h0;
        case (seq_next.state)
            LBT_TERM: begin
                seq_next.lamps[`LBT_LAMP_A] = 1'b1;
                seq_next.lamps[`LBT_LAMP_B] = seq_next.blink;
                seq_next.lamps[`LBT_LAMP_C] = seq_next.blink;
                seq_next.lamps[20:`LBT_LAMP_PORT0] = seq_next.act_seen;
            end
            LBT_MODEM: begin
                seq_next.lamps[`LBT_LAMP_A] = (seq_next.hold_cnt != 32'h0);
                seq_next.lamps[`LBT_LAMP_C] = 1'b1;
                seq_next.lamps[`LBT_LAMP_D] = 1'b1;
            end
            LBT_MFAIL: begin
                seq_next.lamps[20:`LBT_LAMP_B] = `LBT_MODEM_ERR_CODE;
            end
            LBT_DIAG: begin
                seq_next.lamps[`LBT_LAMP_A] = (seq_next.hold_cnt != 32'h0);
                seq_next.lamps[`LBT_LAMP_C] = 1'b1;
            end
            default: begin
                seq_next.lamps = 21'h0;
            end
        endcase

        // Register writes
        if (reg_wr) begin
            if (reg_addr == `LBT_REG_CTRL) begin
                seq_next.rate_9600 = reg_wdata[0];
            end else if (reg_addr == `LBT_REG_STATUS) begin
                ev_clr = reg_wdata[3:0];
            end else if (reg_addr == `LBT_REG_MASK) begin
                seq_next.mask = reg_wdata[3:0];
            end else if (reg_addr == `LBT_REG_ENQACK) begin
                seq_next.enqack = reg_wdata[15:0];
            end
        end
        // A new event wins over a clear in the same cycle
        seq_next.status = (seq_reg.status & ~ev_clr) | ev_set;
        seq_next.irq = |(seq_next.status & seq_next.mask);

        // Read data stand for exactly the cycle after the strobe
        seq_next.rdata = 32'h0;
        if (reg_rd) begin
            if (reg_addr == `LBT_REG_CTRL) begin
                seq_next.rdata = {31'h0, seq_reg.rate_9600};
            end else if (reg_addr == `LBT_REG_STATUS) begin
                seq_next.rdata = {28'h0, seq_reg.status};
            end else if (reg_addr == `LBT_REG_MASK) begin
                seq_next.rdata = {28'h0, seq_reg.mask};
            end else if (reg_addr == `LBT_REG_ENQACK) begin
                seq_next.rdata = {16'h0, seq_reg.enqack};
            end else if (reg_addr == `LBT_REG_MODE) begin
                seq_next.rdata = {18'h0, seq_reg.state, seq_reg.sw};
            end else if (reg_addr == `LBT_REG_CYCLES) begin
                seq_next.rdata = seq_reg.cycles;
            end else if (reg_addr == `LBT_REG_LAMPS) begin
                seq_next.rdata = {11'h0, seq_reg.lamps};
            end else begin
                seq_next.rdata = 32'h0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seq_reg <= '{
                state: LBT_WAIT_POST,
                rate_9600: `LBT_CTRL_RESET,
                mask: `LBT_MASK_RESET,
                enqack: `LBT_ENQACK_RESET,
                tx_lfsr: `LBT_MODEM_SEED,
                rx_lfsr: `LBT_MODEM_SEED,
                default: '0
            };
        end else begin
            seq_reg <= seq_next;
        end
    end

    assign lamps = seq_reg.lamps;
    assign reg_rdata = seq_reg.rdata;
    assign irq = seq_reg.irq;
    assign net_tx = seq_reg.net_tx;
    // Only the rate choice lives here; the serial cells themselves sit outside this block
    assign port_rate_9600 = seq_reg.rate_9600;
endmodule
`default_nettype wire

// ### sim/lbt_sequencer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "lbt_params.svh"
module lbt_sequencer_monitor
    import lbt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic post_done,
    input wire lbt_byte_type [`LBT_NUM_PORTS-1:0] port_rx,
    input wire logic [`LBT_NUM_PORTS-1:0] port_rx_ready,
    input wire lbt_byte_type [`LBT_NUM_PORTS-1:0] port_tx,
    input wire logic [`LBT_NUM_PORTS-1:0] port_tx_ready,
    input wire lbt_byte_type net_tx,
    input wire logic net_tx_ready,
    input wire logic [20:0] lamps,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic port_rate_9600
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    echo_next_a: assert property (port_rx[0].valid && port_rx_ready[0] |=>
        port_tx[0].valid && port_tx[0].data == $past(port_rx[0].data)) else $error("echo missing");
    rx_block_a: assert property (port_tx[0].valid |-> !port_rx_ready[0])
        else $error("rx open while tx pending");
    tx_hold_a: assert property (port_tx[0].valid && !port_tx_ready[0] |=>
        port_tx[0].valid && $stable(port_tx[0].data)) else $error("port tx dropped");
    net_hold_a: assert property (net_tx.valid && !net_tx_ready |=>
        net_tx.valid && $stable(net_tx.data)) else $error("net tx dropped");
    post_gate_a: assert property (!post_done && !$past(post_done) |->
        lamps == 21'h0 && !port_tx[0].valid && !net_tx.valid) else $error("activity before self test");
    modem_lamps_a: assert property (lamps[3] && !lamps[1] |->
        lamps[2] && !lamps[4] && lamps[20:5] == 16'h0) else $error("modem lamps wrong");
    term_lamps_a: assert property (lamps[20:5] != 16'h0 && !lamps[3] |->
        lamps[0] && !lamps[4]) else $error("terminal lamps wrong");
    fail_hold_a: assert property (&lamps[20:1] |-> !lamps[0] ##1 $stable(lamps))
        else $error("failure display not held");
    rate_set_a: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[0] |->
        ##[1:2] port_rate_9600) else $error("rate bit not applied");
    cover property (port_rx[0].valid && port_rx_ready[0]);
    cover property (&lamps[20:1]);
    cover property (reg_wr && reg_addr == 8'h00 && reg_wdata[0]);
endmodule
`default_nettype wire

// ### sim/lbt_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module lbt_far_model
    import lbt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic corrupt,
    output logic [15:0] port_tx_ready,
    input wire lbt_byte_type net_tx,
    output logic net_tx_ready,
    output lbt_byte_type net_rx
);
    logic [1:0] tog;
    // While slow is set, flow control stalls terminals and modem three cycles in four, so every sender must hold
    assign net_tx_ready = slow ? (tog == 2'd0) : 1'b1;
    assign port_tx_ready = {16{net_tx_ready}};
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tog <= 2'd0;
            net_rx <= '0;
        end else begin
            tog <= tog + 2'd1;
            net_rx.valid <= net_tx.valid && net_tx_ready;
            // Idle data inverts so nothing can lean on a stale byte
            net_rx.data <= (net_tx.valid && net_tx_ready) ? net_tx.data ^ {7'h0, corrupt} : ~net_rx.data;
        end
    end
endmodule
`default_nettype wire

// ### sim/lbt_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lbt_sequencer_tb_top;
    import lbt_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] cfg_switches = 8'h05;
    logic post_done = 1'b0;
    logic post_fail = 1'b0;
    logic diag_pass = 1'b0;
    logic slow = 1'b0;
    logic corrupt = 1'b0;
    lbt_byte_type [15:0] port_rx = '0;
    lbt_byte_type [15:0] port_tx;
    lbt_byte_type net_tx, net_rx;
    logic [15:0] port_rx_ready, port_tx_ready;
    logic port_rate_9600, net_tx_ready, irq;
    logic [20:0] lamps;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, rd_val;
    logic [7:0] q[$], nq[$], v;
    logic [1:0] x;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int waited;
    string s;
    lbt_sequencer #(.PAUSE_CYCLES(50), .BLINK_CYCLES(8), .DIAG_LIT_CYCLES(20)) dut (.clk, .sys_rst, .cfg_switches,
        .post_done, .post_fail, .diag_pass, .port_rx, .port_rx_ready, .port_tx, .port_tx_ready, .port_rate_9600,
        .net_tx, .net_tx_ready, .net_rx, .lamps, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
    lbt_far_model far (.clk, .sys_rst, .slow, .corrupt, .port_tx_ready, .net_tx, .net_tx_ready, .net_rx);
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (!sys_rst && port_tx[0].valid && port_tx_ready[0]) begin
            q.push_back(port_tx[0].data);
        end
        if (!sys_rst && net_tx.valid && net_tx_ready) begin
            nq.push_back(net_tx.data);
        end
        // Hang guard; the scenarios need a few thousand cycles at most
        if (cyc == 40000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rst(logic [7:0] sw);
        @(posedge clk);
        sys_rst <= 1'b1;
        cfg_switches <= sw;
        post_done <= 1'b0;
        tick(12);
        sys_rst <= 1'b0;
        q.delete();
        nq.delete();
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        rd_val = reg_rdata;
    endtask
    // Valid is held until the block takes the character
    task automatic send(int p, logic [7:0] c);
        @(posedge clk);
        port_rx[p] <= {1'b1, c};
        waited = 0;
        do begin
            @(posedge clk);
            waited++;
        end while (!port_rx_ready[p] && waited < 3000);
        port_rx[p] <= {1'b0, ~c};
    endtask
    task automatic waitq(int n);
        waited = 0;
        while (q.size() < n && waited < 3000) begin
            @(posedge clk);
            waited++;
        end
        chk("tx count", n, q.size());
    endtask
    initial begin
        rst(8'h05);
        post_fail <= 1'b1;
        tick(20);
        chk("lamps wait", 0, lamps);
        post_done <= 1'b1;
        tick(60);
        chk("lamps fail", 0, lamps);
        chk("tx fail", 0, q.size());
        rst(8'h05);
        post_fail <= 1'b0;
        post_done <= 1'b1;
        // Switches are taken one cycle after release and the mode starts one cycle later
        tick(2);
        rd(8'h10);
        chk("mode", 32'h0205, rd_val);
        rd(8'h0c);
        chk("enqack rst", 0, rd_val);
        rd(8'h20);
        chk("unmapped", 0, rd_val);
        waitq(36);
        s = "\r\n\nLOOP-BACK TEST FEATURE ENABLED\r\n\n";
        for (int i = 0; i < 36; i++) begin
            chk("banner", s[i], q[i]);
        end
        chk("lamps ade", 3'b001, {lamps[4:3], lamps[0]});
        x = lamps[2:1];
        waited = 0;
        while (lamps[2:1] === x && waited < 20) begin
            tick(1);
            waited++;
        end
        chk("blink", 1, waited <= 9);
        chk("blink bc", {~x}, lamps[2:1]);
        wr(8'h00, 32'h1);
        wr(8'h20, 32'h0);
        rd(8'h00);
        chk("rate", 2'b11, {rd_val[0], port_rate_9600});
        wr(8'h0c, 32'h1);
        wr(8'h08, 32'h2);
        slow <= 1'b1;
        q.delete();
        send(0, 8'h61);
        waited = 0;
        while (!lamps[5] && waited < 20) begin
            tick(1);
            waited++;
        end
        chk("port lamps", 16'h0001, lamps[20:5]);
        send(0, 8'h0d);
        waitq(4);
        chk("line", 32'h610d610d, {q[0], q[1], q[2], q[3]});
        tick(3);
        chk("irq", 1, irq);
        rd(8'h04);
        chk("line flag", 1, rd_val[1]);
        wr(8'h04, 32'h2);
        tick(2);
        chk("irq clear", 0, irq);
        slow <= 1'b0;
        q.delete();
        for (int i = 0; i < 128; i++) begin
            send(0, 8'h41 + 8'(i % 26));
        end
        waitq(257);
        chk("full line", 32'h5841580d, {q[127], q[128], q[255], q[256]});
        for (int i = 0; i < 80; i++) begin
            send(1, 8'h62);
        end
        chk("no pause", 1, waited < 50);
        send(1, 8'h62);
        chk("pause", 1, waited >= 50 && waited < 64);
        rst(8'h06);
        slow <= 1'b1;
        post_done <= 1'b1;
        waited = 0;
        while (!lamps[0] && waited < 1000) begin
            tick(1);
            waited++;
        end
        chk("modem lamps", 21'h0d, lamps);
        v = 8'h01;
        for (int i = 0; i < 64; i++) begin
            chk("pattern", v, nq[i]);
            v = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
        end
        rd(8'h14);
        chk("cycles", 1, rd_val != 0);
        rd(8'h10);
        chk("mode", 32'h0406, rd_val);
        corrupt <= 1'b1;
        tick(20);
        chk("fail lamps", 21'h1ffffe, lamps);
        rd(8'h18);
        chk("lamps reg", 32'h1ffffe, rd_val);
        corrupt <= 1'b0;
        slow <= 1'b0;
        rst(8'h03);
        post_done <= 1'b1;
        tick(5);
        diag_pass <= 1'b1;
        tick(1);
        diag_pass <= 1'b0;
        tick(3);
        chk("diag lit", 2'b11, {lamps[2], lamps[0]});
        tick(25);
        chk("diag off", 2'b10, {lamps[2], lamps[0]});
        end_sim();
    end
endmodule
bind lbt_sequencer lbt_sequencer_monitor mon (.clk, .sys_rst, .post_done, .port_rx, .port_rx_ready, .port_tx,
    .port_tx_ready, .net_tx, .net_tx_ready, .lamps, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .port_rate_9600);
`default_nettype wire
